// *** rtl/shadow_port_defs.vh ***
// Constants for the UART shadow data port: register map, fields, sizes and reset values.
`ifndef SHADOW_PORT_DEFS_VH
`define SHADOW_PORT_DEFS_VH
// ============================================================
// Register map (byte addresses).
`define SHD_BASE_ADDR 32'h50001030
`define SHD_ALIAS_COUNT 5'h10
`define SHD_ALIAS_SPAN 32'h00000040
`define SHD_CTRL_ADDR 32'h50001100
`define SHD_STATUS_ADDR 32'h50001104
`define SHD_IRQ_STATUS_ADDR 32'h50001108
`define SHD_IRQ_MASK_ADDR 32'h5000110C
`define SHD_ADDR_W 32
`define SHD_DATA_W 32
// ============================================================
// Control register fields.
`define CTRL_FIFO_EN_BIT 0
`define CTRL_IR_MODE_BIT 1
`define CTRL_W 2
// ============================================================
// Status register fields.
`define STAT_DR_BIT 0
`define STAT_OE_BIT 1
`define STAT_TX_HOLDING_EMPTY_BIT 5
`define STAT_W 6
// ============================================================
// Interrupt bits: 0 rx data, 1 overrun, 2 tx holding empty.
`define IRQ_W 3
`define IRQ_RX_BIT 0
`define IRQ_OE_BIT 1
`define IRQ_TX_HOLDING_EMPTY_BIT 2
// ============================================================
// FIFO and bit timing.
`define FIFO_DEPTH 5'h10
`define FIFO_PTR_W 4
`define FIFO_CNT_W 5
`define BYTE_W 8
`define BAUD_DIV 16'h006C
`define BAUD_HALF 16'h0036
`define IR_PULSE 16'h0024
`define BIT_CNT_W 4
`define FRAME_BITS 4'h9
`define RESET_BYTE 8'h00
`endif

// *** rtl/shadow_data_port.v ***
// UART shadow data port with receive and transmit FIFOs, serial and infrared lines.
`timescale 1ns/1ps
`default_nettype none
`include "shadow_port_defs.vh"
// What this block does
// - Sixteen consecutive word locations all alias the same receive and transmit data.
// - A read returns in bits 7:0 the byte received on the plain or the infrared input as the mode selects.
// - With FIFOs off, a new character overwrites an unread byte and flags overrun.
// - With FIFOs on, a read returns the oldest entry of the receive FIFO.
// - With the receive FIFO full, a new character is dropped, the contents kept and overrun flagged.
// - Written bytes go out on the plain output, or on the active-low infrared output in infrared mode.
// - With FIFOs off, a write clears the holding-empty flag.
// - With FIFOs off, another write before holding-empty sets again overwrites the pending character.
// - With FIFOs on, up to sixteen characters are accepted before the transmit FIFO is full.
// - A write while the transmit FIFO is full is discarded.

// Bus map: the data location spans sixteen word aliases from the base address.
// Control holds the FIFO enable in bit 0 and the infrared mode in bit 1.
// Status holds data-ready in bit 0, overrun in bit 1 and holding-empty in bit 5.
// Interrupt status and mask share one layout: received, overrun, transmit drained.
// Overrun clears when status is read; an interrupt bit clears when a one is written.
// Read data stand for one cycle after the read strobe and are zero otherwise.
// Both serial lines run eight data bits, no parity and one stop bit.
// One bit lasts the baud divisor plus one clock cycles.

module shadow_data_port (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire [`SHD_ADDR_W-1:0] addr_in,
    input wire [`SHD_DATA_W-1:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [`SHD_DATA_W-1:0] rdata_out,
    input wire sin_in,
    input wire sir_in,
    output reg sout_out,
    output reg sir_n_out,
    output reg irq_out
);
    // ============================================================
    // Input synchronisers for the two serial lines.
    // Both pins come from outside the clock domain, so two flip-flops stand
    // in front of any logic that reads them.
    // The plain line rests high and the infrared line dark; the reset values
    // match those levels so no false start bit follows reset.

    reg sin_s1_r, sin_s2_r, sir_s1_r, sir_s2_r;
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sin_s1_r <= 1'b1;
            sin_s2_r <= 1'b1;
            sir_s1_r <= 1'b0;
            sir_s2_r <= 1'b0;
        end else begin
            sin_s1_r <= sin_in;
            sin_s2_r <= sin_s1_r;
            sir_s1_r <= sir_in;
            sir_s2_r <= sir_s1_r;
        end
    end

    // ============================================================
    // Address decode and control registers.
    reg [`CTRL_W-1:0] ctrl_r;
    reg [`IRQ_W-1:0] irq_stat_r, irq_mask_r;
    wire fifo_en = ctrl_r[`CTRL_FIFO_EN_BIT];
    wire ir_mode = ctrl_r[`CTRL_IR_MODE_BIT];
    wire [`SHD_ADDR_W-1:0] addr_off = addr_in - `SHD_BASE_ADDR;
    wire hit_data = (addr_in >= `SHD_BASE_ADDR) && (addr_off < `SHD_ALIAS_SPAN) &&
        (addr_in[1:0] == 2'b00);
    wire data_rd = rd_in && hit_data;
    wire data_wr = wr_in && hit_data;

    // Unaligned addresses and anything beyond the sixteenth alias miss the data
    // location; such accesses read as zero and writes to them are ignored.
    // Every alias reaches the same storage, so a burst walks the same FIFO.


    // ============================================================
    // Receive storage: 16-entry FIFO, entry 0 doubles as the single buffer.
    reg [`BYTE_W-1:0] rx_mem [0:`FIFO_DEPTH-1];
    reg [`FIFO_PTR_W-1:0] rx_head_r, rx_tail_r;
    reg [`FIFO_CNT_W-1:0] rx_cnt_r;
    reg overrun_r;
    reg rx_done_r;
    reg [`BYTE_W-1:0] rx_byte_r;
    wire rx_pop = data_rd && (rx_cnt_r != 5'h00);
    wire rx_full = fifo_en ? (rx_cnt_r == `FIFO_DEPTH) : 1'b0;
    wire rx_dr = (rx_cnt_r != 5'h00);

    // An arriving character that finds no room counts as an overrun; a read in
    // the same cycle frees the entry, so no overrun is flagged then.
    // This event feeds the interrupt status and matches the status flag.
    wire rx_ovr = rx_done_r && !rx_pop && (fifo_en ? rx_full : rx_dr);


    // Receive FIFO pointers, overwrite in single mode and overrun flag.
    // Without FIFOs the pointers stay at zero and entry 0 acts as the buffer.
    // Switching the mode does not flush stored characters; software drains
    // them first if it cares about their order.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_head_r <= 4'h0;
            rx_tail_r <= 4'h0;
            rx_cnt_r <= 5'h00;
            overrun_r <= 1'b0;
        end else begin
            if (!fifo_en) begin
                rx_head_r <= 4'h0;
                rx_tail_r <= 4'h0;
                if (rx_done_r) begin
                    rx_mem[0] <= rx_byte_r;
                    rx_cnt_r <= 5'h01;
                    if (rx_dr && !rx_pop)
                        overrun_r <= 1'b1;
                    else if (rd_in && addr_in == `SHD_STATUS_ADDR)
                        overrun_r <= 1'b0;
                end else begin
                    if (rx_pop)
                        rx_cnt_r <= 5'h00;
                    if (rd_in && addr_in == `SHD_STATUS_ADDR)
                        overrun_r <= 1'b0;
                end
            end else begin
                if (rx_done_r && !rx_full) begin
                    rx_mem[rx_tail_r] <= rx_byte_r;
                    rx_tail_r <= rx_tail_r + 4'h1;
                end
                if (rx_pop)
                    rx_head_r <= rx_head_r + 4'h1;
                rx_cnt_r <= rx_cnt_r + ((rx_done_r && !rx_full) ? 5'h01 : 5'h00) - (rx_pop ? 5'h01 : 5'h00);
                if (rx_done_r && rx_full && !rx_pop)
                    overrun_r <= 1'b1;
                else if (rd_in && addr_in == `SHD_STATUS_ADDR)
                    overrun_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // Receiver: 8N1 on the plain line or on the infrared pulse line.
    // The sampler starts on a low level, checks the start bit half a bit later
    // and drops a frame whose start bit has gone high again as a glitch.
    // A frame whose stop bit reads low is discarded without a flag.

    wire rx_line = ir_mode ? !sir_s2_r : sin_s2_r;
    reg ir_stretch_r;
    reg [15:0] ir_cnt_r;
    reg rx_busy_r;
    reg [15:0] rx_div_r;
    reg [`BIT_CNT_W-1:0] rx_bit_r;
    wire rx_level = ir_mode ? !ir_stretch_r : rx_line;
    // Infrared pulses are stretched by a full bit past their end so the sampler sees a zero.
    // A remote sender must place its pulse early in the bit window; a late
    // pulse would stretch over the sampling point of the next bit.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ir_stretch_r <= 1'b0;
            ir_cnt_r <= 16'h0000;
        end else if (!rx_line) begin
            ir_stretch_r <= 1'b1;
            ir_cnt_r <= `BAUD_DIV;
        end else if (ir_cnt_r != 16'h0000) begin
            ir_cnt_r <= ir_cnt_r - 16'h0001;
        end else begin
            ir_stretch_r <= 1'b0;
        end
    end
    // Bit sampler: start at half a bit, then one sample per bit time.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_busy_r <= 1'b0;
            rx_div_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_byte_r <= `RESET_BYTE;
            rx_done_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            if (!rx_busy_r) begin
                if (!rx_level) begin
                    rx_busy_r <= 1'b1;
                    rx_div_r <= `BAUD_HALF;
                    rx_bit_r <= 4'h0;
                end
            end else if (rx_div_r != 16'h0000) begin
                rx_div_r <= rx_div_r - 16'h0001;
            end else begin
                rx_div_r <= `BAUD_DIV;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rx_level)
                    rx_busy_r <= 1'b0;
                else if (rx_bit_r == `FRAME_BITS) begin
                    rx_busy_r <= 1'b0;
                    rx_done_r <= rx_level;
                end else if (rx_bit_r != 4'h0)
                    rx_byte_r <= {rx_level, rx_byte_r[7:1]};
            end
        end
    end

    // ============================================================
    // Transmit storage: FIFO, entry 0 is the holding register without FIFOs.
    reg [`BYTE_W-1:0] tx_mem [0:`FIFO_DEPTH-1];
    reg [`FIFO_PTR_W-1:0] tx_head_r, tx_tail_r;
    reg [`FIFO_CNT_W-1:0] tx_cnt_r;
    reg tx_busy_r;
    wire tx_take = !tx_busy_r && (tx_cnt_r != 5'h00);
    wire tx_full = (tx_cnt_r == `FIFO_DEPTH);
    wire tx_holding_empty = (tx_cnt_r == 5'h00);
    wire tx_push = data_wr && (fifo_en ? !tx_full : 1'b1);

    // Transmit FIFO pointers and holding register.
    // Without FIFOs a write always lands in entry 0, replacing a character
    // that the shifter has not yet taken.
    // With FIFOs a write to a full FIFO leaves every entry untouched.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_head_r <= 4'h0;
            tx_tail_r <= 4'h0;
            tx_cnt_r <= 5'h00;
        end else if (!fifo_en) begin
            tx_head_r <= 4'h0;
            tx_tail_r <= 4'h0;
            if (tx_push) begin
                tx_mem[0] <= wdata_in[7:0];
                tx_cnt_r <= 5'h01;
            end else if (tx_take)
                tx_cnt_r <= 5'h00;
        end else begin
            if (tx_push) begin
                tx_mem[tx_tail_r] <= wdata_in[7:0];
                tx_tail_r <= tx_tail_r + 4'h1;
            end
            if (tx_take)
                tx_head_r <= tx_head_r + 4'h1;
            tx_cnt_r <= tx_cnt_r + (tx_push ? 5'h01 : 5'h00) - (tx_take ? 5'h01 : 5'h00);
        end
    end

    // ============================================================
    // Transmitter: shifts start, eight data and stop bits.
    // The shifter takes the next character one cycle after the stop bit
    // ends, so back-to-back frames carry a stop of one bit and one cycle.
    // Holding-empty rises as soon as the shifter takes the last character.

    reg [9:0] tx_shift_r;
    reg [15:0] tx_div_r;
    reg [`BIT_CNT_W-1:0] tx_bit_r;
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_busy_r <= 1'b0;
            tx_shift_r <= 10'h3FF;
            tx_div_r <= 16'h0000;
            tx_bit_r <= 4'h0;
            sout_out <= 1'b1;
            sir_n_out <= 1'b1;
        end else begin
            if (tx_take) begin
                tx_busy_r <= 1'b1;
                tx_shift_r <= {1'b1, tx_mem[tx_head_r], 1'b0};
                tx_div_r <= `BAUD_DIV;
                tx_bit_r <= 4'h0;
            end else if (tx_busy_r) begin
                if (tx_div_r != 16'h0000)
                    tx_div_r <= tx_div_r - 16'h0001;
                else begin
                    tx_div_r <= `BAUD_DIV;
                    tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                    tx_bit_r <= tx_bit_r + 4'h1;
                    if (tx_bit_r == `FRAME_BITS)
                        tx_busy_r <= 1'b0;
                end
            end
            // Plain line carries the bit; infrared sends a short low pulse for each zero.
            sout_out <= ir_mode ? 1'b1 : (tx_busy_r ? tx_shift_r[0] : 1'b1);
            sir_n_out <= !(ir_mode && tx_busy_r && !tx_shift_r[0] && (tx_div_r < `IR_PULSE));
        end
    end

    // ============================================================
    // Sticky interrupt status, write one to clear, set wins.
    // Bit 0 marks a received character, bit 1 an overrun and bit 2 a
    // transmit character taken that left the storage empty.
    // The output is registered from the next status value so it follows
    // a set or a clear in the same cycle as the status bit.

    // The last stored character leaves when the shifter takes it and no write refills.
    wire tx_last = tx_take && !tx_push && (tx_cnt_r == 5'h01);
    wire [`IRQ_W-1:0] irq_evt = {tx_last, rx_ovr, rx_done_r};
    wire [`IRQ_W-1:0] irq_clr = (wr_in && addr_in == `SHD_IRQ_STATUS_ADDR) ? wdata_in[`IRQ_W-1:0] : 3'h0;
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_r <= 2'h0;
            irq_stat_r <= 3'h0;
            irq_mask_r <= 3'h0;
            irq_out <= 1'b0;
        end else begin
            if (wr_in && addr_in == `SHD_CTRL_ADDR)
                ctrl_r <= wdata_in[`CTRL_W-1:0];
            if (wr_in && addr_in == `SHD_IRQ_MASK_ADDR)
                irq_mask_r <= wdata_in[`IRQ_W-1:0];
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
            irq_out <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_mask_r);
        end
    end

    // ============================================================

    // Read data, one cycle after the strobe, zero otherwise.
    // A data read with nothing stored returns the reset byte and pops nothing.
    // The status read clears overrun in the receive process, not here.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in)
            rdata_out <= 32'h00000000;
        else if (!rd_in)
            rdata_out <= 32'h00000000;
        else if (hit_data)
            rdata_out <= {24'h000000, rx_dr ? rx_mem[rx_head_r] : `RESET_BYTE};
        else if (addr_in == `SHD_CTRL_ADDR)
            rdata_out <= {30'h00000000, ctrl_r};
        else if (addr_in == `SHD_STATUS_ADDR)
            rdata_out <= {26'h0000000, tx_holding_empty, 3'h0, overrun_r, rx_dr};
        else if (addr_in == `SHD_IRQ_STATUS_ADDR)
            rdata_out <= {29'h00000000, irq_stat_r};
        else if (addr_in == `SHD_IRQ_MASK_ADDR)
            rdata_out <= {29'h00000000, irq_mask_r};
        else
            rdata_out <= 32'h00000000;
    end

    // ============================================================
    // Limits a user must know.
    // The FIFO depth is fixed at sixteen entries in each direction.
    // The bit time is fixed; there is no divisor register in this block.
    // A character that arrives while a full FIFO is read in the same cycle
    // is dropped without an overrun flag.
    // Changing the mode in the middle of a frame corrupts that frame.
    // Writes to the status register have no effect.
    // The interrupt output goes low one cycle after the mask register becomes zero and stays low while it is zero.
    // Infrared reception expects one short pulse for each zero bit.
    // Infrared transmission puts its pulse at the end of each zero bit.
    // A stop bit of the remote sender must last at least half a bit time.

endmodule // shadow_data_port
`default_nettype wire

// *** bench/shadow_port_chk_sva.sv ***
// Checker of the shadow data port's bus answers, interrupt masking and line timing.
`timescale 1ns/1ps
`default_nettype none
`include "shadow_port_defs.vh"
module shadow_port_chk (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic sout_out,
    input wire logic sir_n_out,
    input wire logic irq_out
);
    // ============================================================
    // Shadow copies of mode and mask, and low-time counters of both outputs.
    logic [1:0] mode_r;
    logic [2:0] mask_r;
    logic [15:0] ir_lo_r;
    logic [15:0] so_lo_r;
    wire is_data = addr_in >= `SHD_BASE_ADDR && addr_in < `SHD_BASE_ADDR + `SHD_ALIAS_SPAN;
    wire is_map = is_data || (addr_in >= `SHD_CTRL_ADDR && addr_in <= `SHD_IRQ_MASK_ADDR);
    // Follows control and mask writes and counts cycles that each line spends low.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_r <= 2'h0;
            mask_r <= 3'h0;
            ir_lo_r <= 16'h0;
            so_lo_r <= 16'h0;
        end else begin
            if (wr_in && addr_in == `SHD_CTRL_ADDR) mode_r <= wdata_in[1:0];
            if (wr_in && addr_in == `SHD_IRQ_MASK_ADDR) mask_r <= wdata_in[2:0];
            ir_lo_r <= sir_n_out ? 16'h0 : ir_lo_r + 16'h1;
            so_lo_r <= sout_out ? 16'h0 : so_lo_r + 16'h1;
        end
    end
    // ============================================================
    // Assertions.
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data present without a read");
    data_reserved_a: assert property ($past(rd_in) && $past(is_data) |-> rdata_out[31:8] == 24'h0)
        else $error("data read upper bits not zero");
    unmapped_zero_a: assert property (rd_in && !is_map |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    irq_masked_a: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq_out)
        else $error("interrupt raised while fully masked");
    ir_pulse_a: assert property ($rose(sir_n_out) |-> ir_lo_r == `IR_PULSE)
        else $error("infrared pulse width wrong");
    sout_bit_a: assert property ($rose(sout_out) |-> so_lo_r % (`BAUD_DIV + 16'h1) == 16'h0)
        else $error("serial low run not whole bit times");
    uart_ir_dark_a: assert property (!mode_r[1] && !$past(mode_r[1]) |-> sir_n_out)
        else $error("infrared output active in plain mode");
    ir_sout_idle_a: assert property (mode_r[1] && $past(mode_r[1]) |-> sout_out)
        else $error("serial output active in infrared mode");
endmodule // shadow_port_chk
bind shadow_data_port shadow_port_chk i_shadow_port_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .sout_out(sout_out), .sir_n_out(sir_n_out), .irq_out(irq_out));
`default_nettype wire

// *** bench/remote_uart_model.sv ***
// Behavioural remote UART that sends and collects 8N1 frames on the serial and infrared lines.
`timescale 1ns/1ps
`default_nettype none
module remote_uart_model (
    input wire logic clk_sys_in,
    input wire logic sout_in,
    input wire logic sir_n_in,
    output logic ser_out,
    output logic ir_out
);
    localparam int BIT_T = 109;
    logic [7:0] got_q[$];
    // Idle levels: the serial line rests high, the infrared line dark.
    initial begin
        ser_out = 1'b1;
        ir_out = 1'b0;
    end
    // Sends one frame, least significant bit first; an infrared zero is a short light pulse.
    task automatic send(input logic [7:0] b, input bit ir);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys_in);
            ser_out <= ir ? 1'b1 : f[i];
            ir_out <= ir & !f[i];
            repeat (36) @(posedge clk_sys_in);
            ir_out <= 1'b0;
            repeat (BIT_T - 37) @(posedge clk_sys_in);
        end
    endtask
    // Collects plain serial frames, sampling each bit at its middle.
    always begin
        logic [7:0] v;
        @(negedge sout_in);
        repeat (BIT_T + BIT_T / 2) @(posedge clk_sys_in);
        for (int i = 0; i < 8; i++) begin
            v[i] = sout_in;
            repeat (BIT_T) @(posedge clk_sys_in);
        end
        got_q.push_back(v);
    end
    // Collects infrared frames: a bit window that saw any pulse holds a zero.
    always begin
        logic [7:0] w;
        @(negedge sir_n_in);
        repeat (BIT_T) @(posedge clk_sys_in);
        for (int i = 0; i < 8; i++) begin
            w[i] = 1'b1;
            repeat (BIT_T) begin
                @(posedge clk_sys_in);
                w[i] = w[i] & sir_n_in;
            end
        end
        got_q.push_back(w);
    end
endmodule // remote_uart_model
`default_nettype wire

// *** bench/shadow_data_port_tb.sv ***
// Self-checking testbench of the UART shadow data port.
`timescale 1ns/1ps
`default_nettype none
`include "shadow_port_defs.vh"
module shadow_data_port_tb;
    logic clk_sys_in, nrst_in, wr_in, rd_in, sin_in, sir_in, sout_out, sir_n_out, irq_out;
    logic [31:0] addr_in, wdata_in, rdata_out;
    int n_fail = 0;
    int tests_run = 0;
    shadow_data_port i_shadow_data_port (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sin_in(sin_in),
        .sir_in(sir_in), .sout_out(sout_out), .sir_n_out(sir_n_out), .irq_out(irq_out));
    remote_uart_model i_remote_uart_model (.clk_sys_in(clk_sys_in), .sout_in(sout_out),
        .sir_n_in(sir_n_out), .ser_out(sin_in), .ir_out(sir_in));
    // ============================================================
    // Clock and watchdog.
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #350000;
        n_fail++;
        $display("[ERR] watchdog expected finish seen hang");
        wrap_up();
    end
    // ============================================================
    // Bus, compare and closing tasks.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 chk(what, exp, rdata_out);
    endtask
    task automatic irq_chk(input logic exp);
        @(posedge clk_sys_in);
        #1 chk("irq", {31'h0, exp}, {31'h0, irq_out});
    endtask
    task automatic rx_chk(input logic [7:0] exp);
        int n = 0;
        while (i_remote_uart_model.got_q.size() == 0 && n < 3000) begin
            @(posedge clk_sys_in);
            n++;
        end
        chk("line byte", {24'h0, exp}, n < 3000 ? {24'h0, i_remote_uart_model.got_q.pop_front()} : 32'hX);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ============================================================
    // Scenarios.
    task automatic fifo_off_tx();
        wr(`SHD_BASE_ADDR, 32'hA5);
        repeat (4) @(posedge clk_sys_in);
        wr(`SHD_BASE_ADDR + 32'h4, 32'h11);
        rd_chk("holding busy", `SHD_STATUS_ADDR, 32'h0);
        wr(`SHD_BASE_ADDR + 32'h3C, 32'h7E);
        rx_chk(8'hA5);
        rx_chk(8'h7E);
        rd_chk("tx drained irq", `SHD_IRQ_STATUS_ADDR, 32'h4);
        rd_chk("holding empty", `SHD_STATUS_ADDR, 32'h20);
    endtask
    task automatic fifo_off_rx();
        wr(`SHD_IRQ_STATUS_ADDR, 32'h7);
        i_remote_uart_model.send(8'h5A, 1'b0);
        i_remote_uart_model.send(8'hC3, 1'b0);
        repeat (20) @(posedge clk_sys_in);
        rd_chk("overrun status", `SHD_STATUS_ADDR, 32'h23);
        rd_chk("newest byte", `SHD_BASE_ADDR + 32'h8, 32'hC3);
        rd_chk("drained status", `SHD_STATUS_ADDR, 32'h20);
        wr(`SHD_IRQ_MASK_ADDR, 32'h2);
        irq_chk(1'b1);
        wr(`SHD_IRQ_STATUS_ADDR, 32'h2);
        irq_chk(1'b0);
        wr(`SHD_IRQ_MASK_ADDR, 32'h0);
    endtask
    task automatic fifo_rx();
        wr(`SHD_CTRL_ADDR, 32'h1);
        for (int i = 0; i < 17; i++) begin
            i_remote_uart_model.send(8'h30 + i[7:0], 1'b0);
        end
        repeat (20) @(posedge clk_sys_in);
        rd_chk("full overrun", `SHD_STATUS_ADDR, 32'h23);
        for (int i = 0; i < 16; i++) begin
            rd_chk("fifo head", `SHD_BASE_ADDR + 32'(4 * i), 32'h30 + 32'(i));
        end
        rd_chk("fifo empty", `SHD_STATUS_ADDR, 32'h20);
    endtask
    task automatic fifo_tx();
        wr(`SHD_BASE_ADDR, 32'h40);
        repeat (8) @(posedge clk_sys_in);
        for (int i = 1; i < 18; i++) begin
            wr(`SHD_BASE_ADDR + 32'(4 * (i % 16)), 32'h40 + 32'(i));
        end
        rd_chk("tx fifo full", `SHD_STATUS_ADDR, 32'h0);
        for (int i = 0; i < 17; i++) begin
            rx_chk(8'h40 + i[7:0]);
        end
        repeat (1200) @(posedge clk_sys_in);
        chk("dropped write", 32'h0, 32'(i_remote_uart_model.got_q.size()));
    endtask
    task automatic infrared();
        wr(`SHD_CTRL_ADDR, 32'h3);
        i_remote_uart_model.send(8'h96, 1'b1);
        repeat (20) @(posedge clk_sys_in);
        rd_chk("ir status", `SHD_STATUS_ADDR, 32'h21);
        rd_chk("ir byte", `SHD_BASE_ADDR + 32'h3C, 32'h96);
        wr(`SHD_BASE_ADDR, 32'h3C);
        rx_chk(8'h3C);
        wr(`SHD_CTRL_ADDR, 32'h0);
    endtask
    // Main sequence: reset, reset values, then each scenario.
    initial begin
        nrst_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 32'h0;
        wdata_in = 32'h0;
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rd_chk("reset status", `SHD_STATUS_ADDR, 32'h20);
        rd_chk("reset data", `SHD_BASE_ADDR, 32'h0);
        rd_chk("unmapped", 32'h50001200, 32'h0);
        fifo_off_tx();
        fifo_off_rx();
        fifo_rx();
        fifo_tx();
        infrared();
        wrap_up();
    end
endmodule // shadow_data_port_tb
`default_nettype wire
